// ---- test/ftw_drive_model.sv ----
// drive-side model: index pulses and a slow disk word sink
`timescale 1ns/1ps
module ftw_drive_model (
  input wire logic ref_clk,
  input wire logic [7:0] disk_data,
  input wire logic [7:0] disk_clock_mark,
  input wire logic disk_valid,
  output logic disk_ready,
  output logic index_pulse_in_n
);
  // ------------------------------------------------------------
  // words taken off the stream, in order
  // ------------------------------------------------------------
  ftw_pkg::ftw_word_t got[$];
  int gap = 0; // cycles since disk_ready was last raised, counted modulo 32
  initial
  begin
    disk_ready = 1'b0;
    index_pulse_in_n = 1'b1;
  end
  // one word per 32 cycles: a slow head keeps the buffer full
  always @(posedge ref_clk)
  begin
    if (disk_ready && disk_valid)
      got.push_back({disk_clock_mark, disk_data});
    gap = (gap + 1) % 32;
    disk_ready <= #1 (gap == 0);
  end
  // one index pulse, eight cycles low, long enough for the synchroniser
  task automatic index_pulse();
    #0 index_pulse_in_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1 index_pulse_in_n = 1'b1;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : index_pulse
endmodule : ftw_drive_model

// ---- test/tb_floppy_track_writer_status.sv ----
// self-checking bench for the track writer and status register
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module tb_floppy_track_writer_status;
  // ------------------------------------------------------------
  // stimulus, outputs and counters
  // ------------------------------------------------------------
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic cs_n = 1'b1;
  logic re_n = 1'b1;
  logic we_n = 1'b1;
  logic [1:0] sel = 2'h0; // {hi, lo}
  logic [7:0] dal_in = 8'h00;
  logic ready_in = 1'b1;
  logic wp_n = 1'b1;
  logic tz_n = 1'b1;
  logic inh_n = 1'b1;
  logic settle = 1'b1; // head settle level
  logic wf = 1'b0; // write fault level
  logic mr_n = 1'b1; // master reset, low active
  logic ocd = 1'b0; // foreign command done pulse
  logic [7:0] oc_got = 8'h00; // last foreign command code handed out
  logic [7:0] dal_out, q, disk_data, disk_clock_mark, occ;
  logic irq_out, byte_request, head_load_out, disk_valid, disk_ready, idx_n, dal_oe, oe, wg, ocv;
  logic [15:0] crc;
  logic [7:0] tx[11] = '{8'hFC, 8'hFE, 8'h01, 8'hF7, 8'hFB, 8'h02, 8'hF7, 8'hF8, 8'hF9, 8'hFA, 8'h4E};
  ftw_pkg::ftw_word_t exp_q[$], got_q[$];
  int err_count = 0;
  int compares = 0;
  int cycles = 0;
  always #12.5 ref_clk = ~ref_clk;
  // every drive level is a bench variable so each status source can be moved
  ftw_track_writer i_ftw_track_writer (.ref_clk(ref_clk), .resetn(resetn), .cs_n(cs_n), .re_n(re_n),
    .we_n(we_n), .reg_select_lo(sel[0]), .reg_select_hi(sel[1]), .dal_in(dal_in), .dal_out(dal_out),
    .dal_oe(dal_oe), .irq_out(irq_out), .byte_request(byte_request), .ready_in(ready_in),
    .write_protect_in_n(wp_n), .track_zero_in_n(tz_n), .index_pulse_in_n(idx_n), .head_settle_in(settle),
    .protect_inhibit_in_n(inh_n), .write_fault_in(wf), .master_reset_in_n(mr_n),
    .head_load_out(head_load_out), .write_gate_out(wg), .disk_data(disk_data),
    .disk_clock_mark(disk_clock_mark), .disk_valid(disk_valid), .disk_ready(disk_ready),
    .other_cmd_valid(ocv), .other_cmd_code(occ), .other_cmd_done(ocd));
  // the hand-off pulse lasts one cycle, so its code is caught here
  always @(posedge ref_clk)
    if (ocv)
      oc_got <= occ;
  ftw_drive_model i_drive (.ref_clk(ref_clk), .disk_data(disk_data), .disk_clock_mark(disk_clock_mark),
    .disk_valid(disk_valid), .disk_ready(disk_ready), .index_pulse_in_n(idx_n));
  // ------------------------------------------------------------
  // host strobe tasks
  // ------------------------------------------------------------
  // strobe held five edges; the wait after covers the synchroniser
  task automatic bus(input logic [1:0] s, input logic wr, input logic [7:0] d);
    sel = s;
    dal_in = d;
    cs_n = 1'b0;
    we_n = !wr;
    re_n = wr;
    repeat (4) @(posedge ref_clk);
    #1 q = dal_out;
    oe = dal_oe;
    @(posedge ref_clk);
    #1 cs_n = 1'b1;
    we_n = 1'b1;
    re_n = 1'b1;
    repeat (9) @(posedge ref_clk);
    #1;
  endtask : bus
  task automatic cmd(input logic [7:0] d);
    bus(ftw_pkg::REG_STATUS_CMD, 1'b1, d);
    `CHK("bus drive", 1'b0, oe)
  endtask : cmd
  // masked status read; reading also clears the interrupt
  task automatic st(input logic [7:0] m, input logic [7:0] e);
    bus(ftw_pkg::REG_STATUS_CMD, 1'b0, 8'h00);
    `CHK("status", e, q & m)
    `CHK("bus drive", 1'b1, oe)
  endtask : st
  task automatic wait_req();
    for (int n = 0; n < 100 && byte_request !== 1'b1; n++)
    begin
      @(posedge ref_clk);
      #1;
    end
    `CHK("request", 1'b1, byte_request)
  endtask : wait_req
  // expected word; zero data is dropped because fills may land anywhere
  task automatic put(input logic [7:0] c, input logic [7:0] b);
    if (b !== 8'h00)
      exp_q.push_back({c, b});
  endtask : put
  task automatic model(input logic [7:0] b);
    if (b == 8'hF7)
    begin
      put(8'hFF, crc[15:8]);
      put(8'hFF, crc[7:0]);
    end
    else
    begin
      if (b >= 8'hF8)
        crc = 16'hFFFF;
      crc = crc ^ {b, 8'h00};
      for (int i = 0; i < 8; i++)
        crc = crc[15] ? ((crc << 1) ^ 16'h1021) : (crc << 1);
      put((b == 8'hFC) ? 8'hD7 : ((b >= 8'hF8) ? 8'hC7 : 8'hFF), b);
    end
  endtask : model
  task automatic report_and_stop();
    $display("mismatches %0d, compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  // hang guard well beyond the thousand-odd cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge ref_clk);
    #1 resetn = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1 inh_n = 1'b0;
    cmd(8'hF0);
    `CHK("irq", 1'b1, irq_out)
    st(8'hFF, 8'h40);
    inh_n = 1'b1;
    ready_in = 1'b0;
    cmd(8'hF0);
    st(8'h81, 8'h80);
    ready_in = 1'b1;
    wf = 1'b1;
    cmd(8'hF0);
    `CHK("head load", 1'b1, head_load_out)
    `CHK("request", 1'b1, byte_request)
    st(8'hA7, 8'h23);
    wf = 1'b0;
    i_drive.index_pulse();
    `CHK("irq", 1'b1, irq_out)
    st(8'h05, 8'h04);
    cmd(8'hF0);
    cmd(8'hD0);
    `CHK("irq", 1'b0, irq_out)
    st(8'h07, 8'h02);
    // each force condition in turn: ready rise, ready fall, index, immediate
    for (int k = 0; k < 4; k++)
    begin
      ready_in = 1'b1;
      cmd(8'hF0);
      ready_in = (k != 0);
      cmd(8'hD0 | (8'h01 << k));
      if (k < 3)
        `CHK("irq early", 1'b0, irq_out)
      if (k == 2)
        i_drive.index_pulse();
      ready_in = (k != 1);
      repeat (6) @(posedge ref_clk);
      #1 `CHK("irq", 1'b1, irq_out)
    end
    ready_in = 1'b1;
    wp_n = 1'b0;
    tz_n = 1'b0;
    cmd(8'hD0);
    st(8'hFF, 8'h64);
    settle = 1'b0;
    st(8'h20, 8'h00);
    wp_n = 1'b1;
    tz_n = 1'b1;
    // a seek-type code is handed out and finished by the other logic
    cmd(8'h1B);
    `CHK("handoff", 8'h1B, oc_got)
    st(8'h01, 8'h01);
    ocd = 1'b1;
    @(posedge ref_clk);
    #1 ocd = 1'b0;
    `CHK("irq", 1'b1, irq_out)
    st(8'h01, 8'h00);
    // master reset alone must raise not ready
    mr_n = 1'b0;
    st(8'h81, 8'h80);
    mr_n = 1'b1;
    // a short track: marks, fields and two crc requests
    cmd(8'hF0);
    crc = 16'hFFFF;
    foreach (tx[i])
    begin
      if (i > 0)
        wait_req();
      bus(ftw_pkg::REG_DATA, 1'b1, tx[i]);
      model(tx[i]);
      if (i == 0)
        i_drive.index_pulse();
    end
    `CHK("write gate", 1'b1, wg)
    repeat (400) @(posedge ref_clk);
    #1 i_drive.index_pulse();
    `CHK("irq", 1'b1, irq_out)
    `CHK("write gate", 1'b0, wg)
    st(8'h05, 8'h04);
    foreach (i_drive.got[i])
      if (i_drive.got[i].data !== 8'h00)
        got_q.push_back(i_drive.got[i]);
    `CHK("fill", 1'b1, i_drive.got.size() > got_q.size())
    `CHK("words", exp_q.size(), got_q.size())
    foreach (exp_q[i])
      `CHK("word", exp_q[i], got_q[i])
    report_and_stop();
  end
endmodule : tb_floppy_track_writer_status

// ---- verilog/ftw_pkg.sv ----
// shared constants and carrier types for the track writer and status block
package ftw_pkg;

  // ----------------------------------------------------------------
  // register selects (reg_select_hi, reg_select_lo)
  // ----------------------------------------------------------------
  localparam logic [1:0] REG_STATUS_CMD = 2'h0;
  localparam logic [1:0] REG_TRACK = 2'h1;
  localparam logic [1:0] REG_SECTOR = 2'h2;
  localparam logic [1:0] REG_DATA = 2'h3;

  // ----------------------------------------------------------------
  // command codes (upper nibble) and outgoing byte patterns
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_WRITE_TRACK = 4'hF;
  localparam logic [3:0] CMD_FORCE_INT = 4'hD;
  localparam logic [7:0] BYTE_CRC = 8'hF7;
  localparam logic [7:0] BYTE_MARK_FIRST = 8'hF8;
  localparam logic [7:0] BYTE_DATA_MARK_LAST = 8'hFB;
  localparam logic [7:0] BYTE_INDEX_MARK = 8'hFC;
  localparam logic [7:0] BYTE_MARK_LAST = 8'hFE;
  localparam logic [7:0] CLK_NORMAL = 8'hFF;
  localparam logic [7:0] CLK_MARK = 8'hC7;
  localparam logic [7:0] CLK_INDEX = 8'hD7;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [1:0] CRC_BYTES = 2'h2;

  // ----------------------------------------------------------------
  // state encodings
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {W_IDLE = 3'b001, W_ARM = 3'b010, W_WRITE = 3'b100} ftw_wstate_t;
  typedef enum logic [2:0] {SM_TYPE1 = 3'b001, SM_TRACK = 3'b010, SM_FROZEN = 3'b100} ftw_smode_t;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] clk_mark; // clock pattern sent with the byte
    logic [7:0] data;     // data pattern
  } ftw_word_t;

  typedef struct packed {
    logic not_ready_flag;
    logic protect_or_type_msb_flag;
    logic headload_fault_type_lsb_flag;
    logic seek_or_not_found_flag;
    logic crc_error_flag;
    logic track0_or_lost_flag;
    logic index_or_request_flag;
    logic busy_flag;
  } ftw_status_t;

  typedef struct packed {
    logic cs_n;
    logic re_n;
    logic we_n;
    logic [1:0] sel;
    logic [7:0] dal;
    logic ready;
    logic wp_n;
    logic tr0_n;
    logic idx_n;
    logic settle;
    logic inhibit_n;
    logic fault;
    logic mreset_n;
  } ftw_pins_t;

  // idle level of the pins: strobes and active-low lines released
  localparam ftw_pins_t PINS_IDLE = '{cs_n: 1'b1, re_n: 1'b1, we_n: 1'b1, sel: 2'h0, dal: 8'h00,
    ready: 1'b0, wp_n: 1'b1, tr0_n: 1'b1, idx_n: 1'b1, settle: 1'b0, inhibit_n: 1'b1,
    fault: 1'b0, mreset_n: 1'b1};
  localparam ftw_status_t STATUS_RESET = 8'h00;

endpackage : ftw_pkg

// ---- verilog/ftw_track_writer.sv ----
// track writer, force interrupt and status register of the disk controller
// Functional notes
// - write track: head load and busy first
// - write between first and next index
// - request at once; wait first byte
// - buffer empty at index: abort, lost
// - missing byte is written as zeros
// - special bytes pick their clock patterns
// - mark bytes restart the CRC generator
// - one F7 byte writes two CRC bytes
// - inhibit low refuses, sets protect, interrupts
// - force interrupt on chosen condition
// - no condition: end command, no interrupt
// - new command sets busy, refreshes status
// - force while busy keeps other bits
// - force while idle shows seek status
// - bit 7 is not ready or reset
// - seek status mirrors drive inputs
// - seek and CRC errors read zero
// - no track command when not ready
// - bits 6,5 protect and fault here
// - not-found and CRC bits read zero
// - lost data, request mirror, busy
// - two selects pick the register
`timescale 1ns/1ps
module ftw_track_writer #(
  parameter int DEPTH = 2 // entries of the outgoing byte buffer
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic cs_n,
  input wire logic re_n,
  input wire logic we_n,
  input wire logic reg_select_lo,
  input wire logic reg_select_hi,
  input wire logic [7:0] dal_in,
  output logic [7:0] dal_out,
  output logic dal_oe,
  output logic irq_out,
  output logic byte_request,
  input wire logic ready_in,
  input wire logic write_protect_in_n,
  input wire logic track_zero_in_n,
  input wire logic index_pulse_in_n,
  input wire logic head_settle_in,
  input wire logic protect_inhibit_in_n,
  input wire logic write_fault_in,
  input wire logic master_reset_in_n,
  output logic head_load_out,
  output logic write_gate_out,
  output logic [7:0] disk_data,
  output logic [7:0] disk_clock_mark,
  output logic disk_valid,
  input wire logic disk_ready,
  output logic other_cmd_valid,
  output logic [7:0] other_cmd_code,
  input wire logic other_cmd_done
);

  // ----------------------------------------------------------------
  // structure checks and local types
  // ----------------------------------------------------------------
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin : g_bad_depth
      $error("DEPTH must be a power of two, at least 2");
    end
  endgenerate

  typedef struct packed {
    ftw_pkg::ftw_pins_t sy1;        // first synchroniser stage
    ftw_pkg::ftw_pins_t sy2;        // settled pin levels
    ftw_pkg::ftw_pins_t sy3;        // previous settled levels, for edges
    ftw_pkg::ftw_wstate_t wstate;   // track writer sequence
    ftw_pkg::ftw_smode_t smode;     // which status interpretation is live
    ftw_pkg::ftw_status_t status;   // status register
    logic busy;
    logic irq;
    logic head_load;
    logic write_gate;
    logic byte_request;
    logic buf_full;                 // host byte waiting in byte_buffer
    logic [7:0] byte_buffer;
    logic [7:0] track;
    logic [7:0] sector;
    logic [7:0] rd_data;            // registered read data
    logic lost;
    logic protect;
    logic fault;
    logic [2:0] int_cond;           // armed force-interrupt conditions
    logic [15:0] crc;
    logic [1:0] crc_pend;           // CRC bytes still to send
    logic other_valid;
    logic [7:0] other_code;
    ftw_pkg::ftw_word_t [DEPTH-1:0] fifo;
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [CW-1:0] count;
  } ftw_state_t;

  ftw_state_t s;
  ftw_state_t next_s;

  // comb helpers, also watched by the assertions
  ftw_pkg::ftw_pins_t p;
  ftw_pkg::ftw_pins_t q;
  logic we_take;
  logic rd_done;
  logic idx_edge;
  logic cmd_take;
  logic wt_go;
  logic fi_take;
  logic push;
  logic pop;
  logic [7:0] out_byte;
  ftw_pkg::ftw_word_t push_word;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // one byte through the CCITT generator, msb first
  function automatic logic [15:0] ftw_crc_step(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (r[15] ^ d[i])
        r = {r[14:0], 1'b0} ^ ftw_pkg::CRC_POLY;
      else
        r = {r[14:0], 1'b0};
    end
    return r;
  endfunction : ftw_crc_step

  // pattern F8..FE, which restarts the CRC
  function automatic logic ftw_is_mark(input logic [7:0] d);
    return d >= ftw_pkg::BYTE_MARK_FIRST && d <= ftw_pkg::BYTE_MARK_LAST;
  endfunction : ftw_is_mark

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    p = s.sy2;
    q = s.sy3;
    // every pin goes through two flops before use
    next_s.sy1 = '{cs_n: cs_n, re_n: re_n, we_n: we_n, sel: {reg_select_hi, reg_select_lo},
      dal: dal_in, ready: ready_in, wp_n: write_protect_in_n, tr0_n: track_zero_in_n,
      idx_n: index_pulse_in_n, settle: head_settle_in, inhibit_n: protect_inhibit_in_n,
      fault: write_fault_in, mreset_n: master_reset_in_n};
    next_s.sy2 = s.sy1;
    next_s.sy3 = s.sy2;
    // a write is taken at the trailing edge of we_n, with the values seen while it was low
    we_take = !q.we_n && p.we_n && !q.cs_n;
    rd_done = !q.re_n && p.re_n && !q.cs_n;
    idx_edge = q.idx_n && !p.idx_n;
    cmd_take = we_take && q.sel == ftw_pkg::REG_STATUS_CMD;
    fi_take = cmd_take && q.dal[7:4] == ftw_pkg::CMD_FORCE_INT;
    wt_go = 1'b0;
    push = 1'b0;
    out_byte = ftw_pkg::FILL_BYTE;
    push_word = '{clk_mark: ftw_pkg::CLK_NORMAL, data: ftw_pkg::FILL_BYTE};
    pop = disk_valid && disk_ready;
    next_s.other_valid = 1'b0;
    next_s.rd_data = 8'h00;

    // register reads: data from flops, status read drops the interrupt
    unique case (p.sel)
      ftw_pkg::REG_STATUS_CMD: next_s.rd_data = s.status;
      ftw_pkg::REG_TRACK: next_s.rd_data = s.track;
      ftw_pkg::REG_SECTOR: next_s.rd_data = s.sector;
      ftw_pkg::REG_DATA: next_s.rd_data = s.byte_buffer;
    endcase
    if (rd_done && q.sel == ftw_pkg::REG_STATUS_CMD)
      next_s.irq = 1'b0;

    // plain register writes
    if (we_take && q.sel == ftw_pkg::REG_TRACK)
      next_s.track = q.dal;
    if (we_take && q.sel == ftw_pkg::REG_SECTOR)
      next_s.sector = q.dal;
    if (we_take && q.sel == ftw_pkg::REG_DATA)
    begin
      next_s.byte_buffer = q.dal;
      next_s.buf_full = 1'b1;
    end

    // fault is sticky while the track command runs
    if (s.busy && s.smode == ftw_pkg::SM_TRACK && p.fault)
      next_s.fault = 1'b1;

    // track writer sequence
    unique case (s.wstate)
      ftw_pkg::W_IDLE:
      begin
      end
      ftw_pkg::W_ARM:
      begin
        if (idx_edge && s.buf_full)
        begin
          next_s.wstate = ftw_pkg::W_WRITE;
          next_s.write_gate = 1'b1;
        end
        else if (idx_edge)
        begin
          // nothing to write when the track starts: give up
          next_s.wstate = ftw_pkg::W_IDLE;
          next_s.busy = 1'b0;
          next_s.lost = 1'b1;
          next_s.irq = 1'b1;
          next_s.write_gate = 1'b0;
        end
      end
      ftw_pkg::W_WRITE:
      begin
        if (idx_edge)
        begin
          // second index ends the track; bytes still buffered drain out
          next_s.wstate = ftw_pkg::W_IDLE;
          next_s.busy = 1'b0;
          next_s.irq = 1'b1;
          next_s.write_gate = 1'b0;
        end
        else if (s.count != CW'(DEPTH))
        begin
          push = 1'b1;
          if (s.crc_pend != 2'h0)
          begin
            // second CRC byte, low half
            push_word.data = s.crc[7:0];
            next_s.crc_pend = s.crc_pend - 2'h1;
          end
          else
          begin
            if (s.buf_full)
            begin
              out_byte = s.byte_buffer;
              next_s.buf_full = next_s.buf_full && we_take && q.sel == ftw_pkg::REG_DATA;
            end
            else
              next_s.lost = 1'b1;
            if (out_byte == ftw_pkg::BYTE_CRC)
            begin
              // the F7 itself is never written; it stands for both CRC bytes
              push_word.data = s.crc[15:8];
              next_s.crc_pend = ftw_pkg::CRC_BYTES - 2'h1;
            end
            else if (ftw_is_mark(out_byte))
            begin
              next_s.crc = ftw_crc_step(ftw_pkg::CRC_PRESET, out_byte);
              push_word.data = out_byte;
              if (out_byte <= ftw_pkg::BYTE_DATA_MARK_LAST || out_byte == ftw_pkg::BYTE_MARK_LAST)
                push_word.clk_mark = ftw_pkg::CLK_MARK;
              else if (out_byte == ftw_pkg::BYTE_INDEX_MARK)
                push_word.clk_mark = ftw_pkg::CLK_INDEX;
            end
            else
            begin
              next_s.crc = ftw_crc_step(s.crc, out_byte);
              push_word.data = out_byte;
            end
          end
        end
      end
      default:
      begin
        next_s.wstate = ftw_pkg::W_IDLE;
      end
    endcase

    // armed force-interrupt conditions
    if ((s.int_cond[0] && p.ready && !q.ready) || (s.int_cond[1] && !p.ready && q.ready) ||
        (s.int_cond[2] && idx_edge))
      next_s.irq = 1'b1;

    // work done elsewhere ends busy with an interrupt
    if (other_cmd_done && s.busy && s.smode == ftw_pkg::SM_TYPE1)
    begin
      next_s.busy = 1'b0;
      next_s.irq = 1'b1;
    end

    // command register
    if (fi_take)
    begin
      // accepted in any state; the running command simply stops
      next_s.smode = s.busy ? ftw_pkg::SM_FROZEN : ftw_pkg::SM_TYPE1;
      next_s.busy = 1'b0;
      next_s.wstate = ftw_pkg::W_IDLE;
      next_s.write_gate = 1'b0;
      next_s.crc_pend = 2'h0;
      next_s.int_cond = q.dal[2:0];
      next_s.irq = q.dal[3];
    end
    else if (cmd_take)
    begin
      next_s.irq = 1'b0;
      next_s.int_cond = 3'h0;
      next_s.lost = 1'b0;
      next_s.protect = 1'b0;
      next_s.fault = 1'b0;
      if (q.dal[7:4] == ftw_pkg::CMD_WRITE_TRACK)
      begin
        next_s.smode = ftw_pkg::SM_TRACK;
        if (!p.ready)
          next_s.irq = 1'b1;
        else if (!p.inhibit_n)
        begin
          next_s.protect = 1'b1;
          next_s.irq = 1'b1;
        end
        else
        begin
          wt_go = 1'b1;
          next_s.busy = 1'b1;
          next_s.head_load = 1'b1;
          next_s.buf_full = 1'b0;
          next_s.crc_pend = 2'h0;
          next_s.wstate = ftw_pkg::W_ARM;
        end
      end
      else
      begin
        // seek and sector commands run in other logic
        next_s.smode = ftw_pkg::SM_TYPE1;
        next_s.busy = 1'b1;
        next_s.other_valid = 1'b1;
        next_s.other_code = q.dal;
      end
    end

    // master reset clears command activity
    if (!p.mreset_n)
    begin
      next_s.busy = 1'b0;
      next_s.wstate = ftw_pkg::W_IDLE;
      next_s.write_gate = 1'b0;
      next_s.head_load = 1'b0;
      next_s.smode = ftw_pkg::SM_TYPE1;
      next_s.int_cond = 3'h0;
    end

    // request stands while the track command wants a byte
    next_s.byte_request = next_s.busy && next_s.wstate != ftw_pkg::W_IDLE && !next_s.buf_full;

    // byte buffer toward the serialiser
    if (push)
    begin
      next_s.fifo[s.wr_ptr] = push_word;
      next_s.wr_ptr = s.wr_ptr + PW'(1);
    end
    if (pop)
      next_s.rd_ptr = s.rd_ptr + PW'(1);
    next_s.count = s.count + CW'(push) - CW'(pop);

    // status register, refreshed every cycle; bits 6..1 hold while frozen by force interrupt, bits 7 and 0 never do
    next_s.status.not_ready_flag = !p.ready || !p.mreset_n;
    next_s.status.busy_flag = next_s.busy;
    unique case (next_s.smode)
      ftw_pkg::SM_TYPE1:
      begin
        next_s.status.protect_or_type_msb_flag = !p.wp_n;
        next_s.status.headload_fault_type_lsb_flag = s.head_load && p.settle;
        next_s.status.seek_or_not_found_flag = 1'b0;
        next_s.status.crc_error_flag = 1'b0;
        next_s.status.track0_or_lost_flag = !p.tr0_n;
        next_s.status.index_or_request_flag = !p.idx_n;
      end
      ftw_pkg::SM_TRACK:
      begin
        next_s.status.protect_or_type_msb_flag = next_s.protect;
        next_s.status.headload_fault_type_lsb_flag = next_s.fault;
        next_s.status.seek_or_not_found_flag = 1'b0;
        next_s.status.crc_error_flag = 1'b0;
        next_s.status.track0_or_lost_flag = next_s.lost;
        next_s.status.index_or_request_flag = next_s.byte_request;
      end
      ftw_pkg::SM_FROZEN:
      begin
      end
      default:
      begin
        next_s.smode = ftw_pkg::SM_TYPE1;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.sy1 <= ftw_pkg::PINS_IDLE;
      s.sy2 <= ftw_pkg::PINS_IDLE;
      s.sy3 <= ftw_pkg::PINS_IDLE;
      s.wstate <= ftw_pkg::W_IDLE;
      s.smode <= ftw_pkg::SM_TYPE1;
      s.status <= ftw_pkg::STATUS_RESET;
    end
    else
      s <= next_s;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign dal_out = s.rd_data;
  assign dal_oe = !s.sy2.cs_n && !s.sy2.re_n;
  assign irq_out = s.irq;
  assign byte_request = s.byte_request;
  assign head_load_out = s.head_load;
  assign write_gate_out = s.write_gate;
  assign disk_data = s.fifo[s.rd_ptr].data;
  assign disk_clock_mark = s.fifo[s.rd_ptr].clk_mark;
  assign disk_valid = s.count != CW'(0);
  assign other_cmd_valid = s.other_valid;
  assign other_cmd_code = s.other_code;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  sequence sq_wt_accept;
    wt_go && p.mreset_n;
  endsequence
  sequence sq_force_busy;
    fi_take && s.busy && p.mreset_n;
  endsequence
  // first half of the pair goes out with the plain clock pattern
  sequence sq_crc_high;
    push_word.data == s.crc[15:8] && push_word.clk_mark == ftw_pkg::CLK_NORMAL;
  endsequence
  // the low half is then owed, still inside the writing phase
  sequence sq_crc_low_due;
    s.crc_pend == 2'h1 && s.wstate == ftw_pkg::W_WRITE;
  endsequence

  AST_HEAD_LOAD: assert property (sq_wt_accept |=> head_load_out && s.busy)
    else $error("head load or busy missing after write track");
  AST_REQ_AT_ONCE: assert property (sq_wt_accept |=> byte_request ##0 s.wstate == ftw_pkg::W_ARM)
    else $error("request not raised on write track");
  AST_LOST_ABORT: assert property (s.wstate == ftw_pkg::W_ARM && idx_edge && !s.buf_full && !cmd_take
    && p.mreset_n |=> !s.busy && s.lost && irq_out)
    else $error("empty buffer at index did not abort");
  AST_ZERO_FILL: assert property (push && s.crc_pend == 2'h0 && !s.buf_full |-> push_word.data == 8'h00)
    else $error("missing byte not replaced by zeros");
  AST_MARK_CLOCK: assert property (push && s.crc_pend == 2'h0 && s.buf_full && (s.byte_buffer == 8'hFE
    || s.byte_buffer == 8'hF9) |-> push_word.clk_mark == 8'hC7)
    else $error("mark written with wrong clock");
  AST_CRC_RESTART: assert property (push && s.crc_pend == 2'h0 && s.buf_full && ftw_is_mark(s.byte_buffer)
    && !fi_take |=> s.crc == ftw_crc_step(16'hFFFF, $past(s.byte_buffer)))
    else $error("crc not restarted on mark");
  AST_CRC_PAIR: assert property (push && s.crc_pend == 2'h0 && s.buf_full && s.byte_buffer == 8'hF7
    && !fi_take && p.mreset_n |-> sq_crc_high ##1 sq_crc_low_due)
    else $error("F7 did not start a crc pair");
  AST_PROTECT_REFUSE: assert property (cmd_take && q.dal[7:4] == 4'hF && p.ready && !p.inhibit_n
    && p.mreset_n |=> !s.busy && irq_out && s.status.protect_or_type_msb_flag)
    else $error("inhibited write track not refused");
  AST_FORCE_KEEP: assert property (sq_force_busy |=> !s.busy
    && s.status[6:1] == $past(s.status[6:1]))
    else $error("force interrupt changed status bits");
  AST_FORCE_QUIET: assert property (fi_take && q.dal[3:0] == 4'h0 |=> !irq_out && !s.busy [*2])
    else $error("force with no condition interrupted");

endmodule : ftw_track_writer
